// ### pkg/mfs_params.svh
// Constants of the mesh frame security engine
`ifndef MFS_PARAMS_SVH
`define MFS_PARAMS_SVH
// ----------------------------------------
// Counters
// ----------------------------------------
`define MFS_CTR_MAX 32'h0FFFFFFF
`define MFS_CTR_ZERO 32'h00000000
`define MFS_CTR_ONE 32'h00000001
`define MFS_SEQ_ONE 8'h01
`define MFS_SEQ_ZERO 8'h00
// ----------------------------------------
// Frame overhead in bytes
// ----------------------------------------
`define MFS_TAG_BYTES 8'h04
`define MFS_SRC_BYTES 8'h08
`define MFS_CTR_BYTES 8'h04
`define MFS_NWK_OTHER 8'h02
`define MFS_APS_HDR 8'h05
`endif

// ### pkg/mfs_pkg.sv
// Types of the mesh frame security engine
package mfs_pkg;
    // ----------------------------------------
    // Frame kinds and verdicts
    // ----------------------------------------
    typedef enum logic [2:0] {
        KIND_DATA, KIND_ROUTE_REQ, KIND_ROUTE_REP, KIND_APS_CMD, KIND_ZDO_CMD, KIND_MAC
    } mfs_kind_t;
    typedef enum logic [3:0] {
        V_SENT, V_PLAIN, V_DELIVERED, V_FORWARD, V_REPLAY, V_NWK_TAG, V_APS_TAG,
        V_EXHAUSTED, V_APS_BCAST, V_KEY_LINK, V_KEY_CLEAR, V_KEY_REFUSED, V_KEY_NEW
    } mfs_verdict_t;
    typedef enum logic [1:0] {K_ADOPT, K_DELIVER, K_RECEIVE} mfs_key_op_t;
    typedef enum logic [1:0] {A_ENC_AUTH, A_DEC_AUTH, A_WRAP, A_UNWRAP} mfs_aes_op_t;
    // ----------------------------------------
    // Request, command and result carriers
    // ----------------------------------------
    typedef struct packed {
        mfs_kind_t kind;    // Frame kind
        logic bcast;        // Broadcast destination
        logic aps_req;      // Application-layer security wanted
    } mfs_tx_t;
    typedef struct packed {
        mfs_kind_t kind;    // Frame kind
        logic bcast;        // Broadcast destination
        logic for_me;       // Addressed to this node
        logic aps_sec;      // Carries application-layer security
        logic [7:0] nbr;    // Sending neighbour index
        logic [63:0] src;   // Source address in header
        logic [31:0] ctr;   // Frame counter in header
        logic [31:0] nwk_tag; // Received network integrity_tag
        logic [31:0] aps_tag; // Received application integrity_tag
    } mfs_rx_t;
    typedef struct packed {
        mfs_key_op_t op;    // Adopt, deliver or receive key
        logic joiner_link;  // Joiner holds trust-centre link key
    } mfs_key_t;
    typedef struct packed {
        mfs_aes_op_t op;    // Cipher operation
        logic link_key;     // 1 link key, 0 network key
        logic aps_scope;    // 1 application layer, 0 network layer
        logic [63:0] src;   // Source address for nonce
        logic [31:0] ctr;   // Frame counter for nonce
    } mfs_aes_t;
    typedef struct packed {
        mfs_verdict_t verdict; // Outcome
        logic [31:0] ctr;      // Counter placed in header
        logic [31:0] nwk_tag;  // Network integrity_tag
        logic [31:0] aps_tag;  // Application integrity_tag
    } mfs_res_t;
endpackage

// ### sim/mfs_cipher_model.sv
// Behavioural cipher core facing the frame security engine
`timescale 1ns/1ps
module mfs_cipher_model import mfs_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pacing: high gives a slow core
    input wire logic slow,
    // Command side
    input wire logic aes_valid,
    input wire mfs_aes_t aes_cmd,
    // Answer side
    output logic aes_done,
    output logic [31:0] aes_tag
);
    logic [3:0] cnt_q; // Cycles spent on the command
    logic [31:0] hash; // Stand-in for the 128-bit keyed hash
    // Key choice and scope enter the tag, so the two tags differ
    assign hash = aes_cmd.ctr ^ aes_cmd.src[31:0] ^ aes_cmd.src[63:32]
        ^ {28'h0000000, aes_cmd.op, aes_cmd.link_key, aes_cmd.aps_scope};
    // Tag is only valid with the done pulse; otherwise inverted
    assign aes_tag = aes_done ? hash : ~hash;
    // Done one or five cycles after the command is seen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
            aes_done <= 1'b0;
        end else if (aes_valid && !aes_done && cnt_q >= (slow ? 4'h4 : 4'h0)) begin
            cnt_q <= 4'h0;
            aes_done <= 1'b1;
        end else begin
            cnt_q <= (aes_valid && !aes_done) ? cnt_q + 4'h1 : 4'h0;
            aes_done <= 1'b0;
        end
    end
endmodule

// ### sim/mfs_engine_asserts.sv
// Assertion checker for the frame security engine
`timescale 1ns/1ps
module mfs_engine_chk import mfs_pkg::*; #(
    parameter int NBR_N = 16,
    parameter logic [7:0] FRAME_MAX = 8'h7F
) (
    // Clock, reset, address
    input wire logic clk,
    input wire logic reset,
    input wire logic [63:0] own_addr,
    // Requests
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire mfs_tx_t tx_req,
    input wire logic [7:0] tx_payload_cap,
    input wire logic key_valid,
    input wire logic key_ready,
    input wire mfs_key_t key_req,
    input wire logic [7:0] key_seq,
    // Cipher core and results
    input wire logic aes_valid,
    input wire mfs_aes_t aes_cmd,
    input wire logic aes_done,
    input wire logic res_valid,
    input wire mfs_res_t res
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [31:0] ctr_q; // Expected outgoing counter
    wire tx_take = tx_valid && tx_ready; // Frame taken
    wire sent = res_valid && (res.verdict == V_SENT || res.verdict == V_FORWARD);
    // Zero on new key, step on each secured send
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctr_q <= 32'h00000000;
        end else if (res_valid && res.verdict == V_KEY_NEW) begin
            ctr_q <= 32'h00000000;
        end else if (sent) begin
            ctr_q <= ctr_q + 32'h00000001;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_mac_plain: assert property (tx_take && tx_req.kind == KIND_MAC && !tx_req.aps_req
        |=> res_valid && res.verdict == V_PLAIN && !aes_valid) else $error("mac not plain");
    a_aps_bcast: assert property (tx_take && tx_req.bcast && tx_req.aps_req
        |=> res_valid && res.verdict == V_APS_BCAST && !aes_valid) else $error("aps bcast");
    a_key_step: assert property (key_valid && key_ready && key_req.op == K_ADOPT
        |=> res_valid && res.verdict == V_KEY_NEW && key_seq == $past(key_seq) + 8'h01)
        else $error("key step");
    a_cap_size: assert property (tx_payload_cap == FRAME_MAX - 8'h12
        - (tx_req.aps_req ? 8'h09 : 8'h00)) else $error("payload cap");
    a_ctr_step: assert property (sent |-> res.ctr == ctr_q) else $error("counter");
    a_cmd_hold: assert property (aes_valid && !aes_done
        |=> aes_valid && $stable(aes_cmd)) else $error("cmd moved");
    a_own_src: assert property (aes_valid && aes_cmd.op == A_ENC_AUTH && !aes_cmd.aps_scope
        |-> aes_cmd.src == own_addr && aes_cmd.ctr == ctr_q) else $error("own src");
    a_hop_auth: assert property (res_valid && (res.verdict inside {V_DELIVERED, V_FORWARD,
        V_NWK_TAG}) |-> $past(aes_done)) else $error("no auth");
endmodule
bind mfs_engine mfs_engine_chk #(.NBR_N(NBR_N), .FRAME_MAX(FRAME_MAX)) u_chk (
    .clk(clk), .reset(reset), .own_addr(own_addr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_req(tx_req), .tx_payload_cap(tx_payload_cap),
    .key_valid(key_valid), .key_ready(key_ready), .key_req(key_req), .key_seq(key_seq),
    .aes_valid(aes_valid), .aes_cmd(aes_cmd), .aes_done(aes_done),
    .res_valid(res_valid), .res(res));

// ### sim/testbench.sv
// Self-checking bench of the frame security engine
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench import mfs_pkg::*; ;
    localparam logic [7:0] FMAX = 8'h7F; // Frame size
    localparam logic [63:0] PEER = 64'hFEDCBA9876543210; // Neighbour address
    logic clk = 1'b0, reset = 1'b1, slow = 1'b0; // Clock, reset, pacing
    logic is_trust_centre = 1'b0, allow_clear_key = 1'b0; // Node role
    logic tx_valid = 1'b0, rx_valid = 1'b0, key_valid = 1'b0; // Requests
    logic [63:0] own_addr = 64'h0123456789ABCDEF; // Own address
    mfs_tx_t tx_req = '0;
    mfs_rx_t rx_req = '0;
    mfs_key_t key_req = '0;
    logic tx_ready, rx_ready, key_ready, aes_valid, aes_done, res_valid;
    logic [7:0] tx_payload_cap, key_seq, eseq; // eseq: expected sequence
    logic [31:0] aes_tag, ectr; // ectr: expected counter
    mfs_aes_t aes_cmd;
    mfs_res_t res, r; // r: last result taken
    int mismatches = 0, compares = 0;
    always #10 clk = ~clk;
    mfs_engine #(.NBR_N(16), .FRAME_MAX(FMAX)) u_dut (.clk(clk), .reset(reset),
        .own_addr(own_addr), .is_trust_centre(is_trust_centre),
        .allow_clear_key(allow_clear_key), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_req(tx_req), .tx_payload_cap(tx_payload_cap), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_req(rx_req), .key_valid(key_valid), .key_ready(key_ready),
        .key_req(key_req), .key_seq(key_seq), .aes_valid(aes_valid), .aes_cmd(aes_cmd),
        .aes_done(aes_done), .aes_tag(aes_tag), .res_valid(res_valid), .res(res));
    mfs_cipher_model u_core (.clk(clk), .reset(reset), .slow(slow), .aes_valid(aes_valid),
        .aes_cmd(aes_cmd), .aes_done(aes_done), .aes_tag(aes_tag));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Expected tag of the stand-in core
    function automatic logic [31:0] tg(mfs_aes_op_t op, logic lk, logic ap, logic [63:0] s,
        logic [31:0] c);
        return c ^ s[31:0] ^ s[63:32] ^ {28'h0000000, op, lk, ap};
    endfunction
    // Received frame from the neighbour, good or bad network tag
    function automatic mfs_rx_t mk(logic me, logic ap, logic [7:0] nb, logic [31:0] c,
        logic ok);
        mfs_rx_t x;
        x = '{KIND_DATA, 1'b0, me, ap, nb, PEER, c, tg(A_DEC_AUTH, 1'b0, 1'b0, PEER, c), '0};
        x.nwk_tag = ok ? x.nwk_tag : ~x.nwk_tag;
        x.aps_tag = ~tg(A_DEC_AUTH, 1'b1, 1'b1, PEER, c);
        return x;
    endfunction
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Wait for idle, bounded
    task automatic idle;
        for (int n = 0; n < 200 && key_ready !== 1'b1; n++) @(negedge clk);
        if (key_ready !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask
    // Wait for the result pulse, bounded
    task automatic wait_res;
        for (int n = 0; n < 200 && res_valid !== 1'b1; n++) @(negedge clk);
        if (res_valid !== 1'b1) begin
            mismatches++;
            summarize();
        end
        r = res;
    endtask
    task automatic do_tx(mfs_tx_t t);
        idle();
        tx_req = t;
        tx_valid = 1'b1;
        @(negedge clk);
        tx_valid = 1'b0;
        wait_res();
    endtask
    task automatic do_rx(mfs_rx_t x, mfs_verdict_t v);
        idle();
        rx_req = x;
        rx_valid = 1'b1;
        @(negedge clk);
        `CHK(rx_ready, v == V_REPLAY);
        rx_valid = 1'b0;
        wait_res();
        `CHK(r.verdict, v);
    endtask
    task automatic do_key(mfs_key_op_t op, logic lk, mfs_verdict_t v);
        idle();
        key_req = '{op, lk};
        key_valid = 1'b1;
        @(negedge clk);
        key_valid = 1'b0;
        wait_res();
        `CHK(r.verdict, v);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Every frame kind, back to back
    task automatic t_kinds;
        for (int k = 0; k < 6; k++) begin
            do_tx('{mfs_kind_t'(k[2:0]), 1'b0, 1'b0});
            if (k == 5) begin
                `CHK(r.verdict, V_PLAIN);
            end else begin
                `CHK(r.verdict, V_SENT);
                `CHK(r.ctr, ectr);
                `CHK(r.nwk_tag, tg(A_ENC_AUTH, 1'b0, 1'b0, own_addr, ectr));
                ectr++;
            end
        end
    endtask
    // Payload room and application security
    task automatic t_aps;
        mfs_rx_t x;
        tx_req = '{KIND_DATA, 1'b0, 1'b0};
        #1 `CHK(tx_payload_cap, FMAX - 8'h12);
        tx_req.aps_req = 1'b1;
        #1 `CHK(tx_payload_cap, FMAX - 8'h1B);
        @(negedge clk);
        do_tx('{KIND_DATA, 1'b1, 1'b1});
        `CHK(r.verdict, V_APS_BCAST);
        do_tx('{KIND_DATA, 1'b0, 1'b1});
        `CHK(r.verdict, V_SENT);
        `CHK(r.aps_tag === r.nwk_tag, 1'b0);
        `CHK(r.aps_tag, tg(A_ENC_AUTH, 1'b1, 1'b1, own_addr, ectr));
        ectr++;
        do_rx(mk(1'b1, 1'b1, 8'h06, 32'h1, 1'b1), V_APS_TAG);
        // Matching application tag is delivered
        x = mk(1'b1, 1'b1, 8'h06, 32'h2, 1'b1);
        x.aps_tag = ~x.aps_tag;
        do_rx(x, V_DELIVERED);
    endtask
    // Replay window per neighbour
    task automatic t_replay;
        do_rx(mk(1'b1, 1'b0, 8'h03, 32'h5, 1'b1), V_DELIVERED);
        do_rx(mk(1'b1, 1'b0, 8'h03, 32'h4, 1'b1), V_REPLAY);
        do_rx(mk(1'b1, 1'b0, 8'h03, 32'h9, 1'b0), V_NWK_TAG);
        do_rx(mk(1'b1, 1'b0, 8'h03, 32'h7, 1'b1), V_DELIVERED);
        do_rx(mk(1'b1, 1'b0, 8'h03, 32'h6, 1'b1), V_REPLAY);
        do_rx(mk(1'b1, 1'b0, 8'h04, 32'h1, 1'b1), V_DELIVERED);
        slow = 1'b1;
        do_rx(mk(1'b0, 1'b0, 8'h05, 32'h2, 1'b1), V_FORWARD);
        `CHK(r.ctr, ectr);
        `CHK(r.nwk_tag, tg(A_ENC_AUTH, 1'b0, 1'b0, own_addr, ectr));
        `CHK(r.aps_tag, ~tg(A_DEC_AUTH, 1'b1, 1'b1, PEER, 32'h2));
        ectr++;
        slow = 1'b0;
    endtask
    // Key delivery, key change and counter restart
    task automatic t_keys;
        do_key(K_DELIVER, 1'b1, V_KEY_REFUSED);
        is_trust_centre = 1'b1;
        do_key(K_DELIVER, 1'b1, V_KEY_LINK);
        do_key(K_DELIVER, 1'b0, V_KEY_REFUSED);
        allow_clear_key = 1'b1;
        do_key(K_DELIVER, 1'b0, V_KEY_CLEAR);
        do_key(K_RECEIVE, 1'b1, V_KEY_NEW);
        do_key(K_ADOPT, 1'b0, V_KEY_NEW);
        eseq = eseq + 8'h02;
        `CHK(key_seq, eseq);
        do_rx(mk(1'b1, 1'b0, 8'h03, 32'h0, 1'b1), V_DELIVERED);
        do_tx('{KIND_DATA, 1'b0, 1'b0});
        `CHK(r.ctr, 32'h00000000);
    endtask
    // Main sequence
    initial begin
        ectr = 32'h00000000;
        eseq = 8'h00;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        `CHK(key_seq, eseq);
        t_kinds();
        t_aps();
        t_replay();
        t_keys();
        summarize();
    end
endmodule

// ### verilog/mfs_engine.sv
// Frame security sequencer of the mesh radio node
`timescale 1ns/1ps
`include "mfs_params.svh"
module mfs_engine import mfs_pkg::*; #(
    parameter int NBR_N = 16,
    parameter logic [7:0] FRAME_MAX = 8'h7F
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Node configuration
    input wire logic [63:0] own_addr,
    input wire logic is_trust_centre,
    input wire logic allow_clear_key,
    // Outgoing frames
    input wire logic tx_valid,
    output logic tx_ready,
    input wire mfs_tx_t tx_req,
    output logic [7:0] tx_payload_cap,
    // Received frames
    input wire logic rx_valid,
    output logic rx_ready,
    input wire mfs_rx_t rx_req,
    // Key events
    input wire logic key_valid,
    output logic key_ready,
    input wire mfs_key_t key_req,
    output logic [7:0] key_seq,
    // Cipher core
    output logic aes_valid,
    output mfs_aes_t aes_cmd,
    input wire logic aes_done,
    input wire logic [31:0] aes_tag,
    // Results
    output logic res_valid,
    output mfs_res_t res
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam int NBR_W = (NBR_N > 1) ? $clog2(NBR_N) : 1;
    typedef enum logic [2:0] {
        S_IDLE, S_TX_APS, S_TX_NWK, S_RX_NWK, S_RX_APS, S_FWD, S_KEY
    } mfs_st_t;
    mfs_st_t state_q, state_d;          // Sequencer state
    logic [31:0] ctr_q, ctr_d;          // Outgoing frame counter
    logic [7:0] seq_q, seq_d;           // Network key sequence number
    logic [31:0] nbr_ctr_q [NBR_N];     // Neighbour counters
    logic [31:0] aps_tag_q, aps_tag_d;  // Application tag of frame in flight
    mfs_rx_t rx_q;                      // Held received frame
    mfs_key_t key_q;                    // Held key request
    logic aes_valid_q, aes_valid_d;     // Cipher request pending
    mfs_aes_t aes_cmd_q, aes_cmd_d;     // Cipher command
    logic res_valid_q, res_valid_d;     // Result strobe
    mfs_res_t res_q, res_d;             // Result
    logic nbr_clr;                      // Zero all neighbour counters
    logic nbr_we;                       // Write neighbour counter
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Frame kinds that carry network security
    function automatic logic secured_kind(input mfs_kind_t k);
        secured_kind = (k != KIND_MAC);
    endfunction
    // Build a cipher command
    function automatic mfs_aes_t mk_aes(input mfs_aes_op_t op, input logic link,
                                        input logic aps, input logic [63:0] src,
                                        input logic [31:0] ctr);
        mk_aes = '{op: op, link_key: link, aps_scope: aps, src: src, ctr: ctr};
    endfunction
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire tx_fire = tx_valid && tx_ready;
    wire rx_fire = rx_valid && rx_ready;
    wire key_fire = key_valid && key_ready;
    wire exhausted = (ctr_q == `MFS_CTR_MAX);
    wire [NBR_W-1:0] rx_idx_in = rx_req.nbr[NBR_W-1:0];
    wire [NBR_W-1:0] rx_idx_q = rx_q.nbr[NBR_W-1:0];
    wire replay = rx_req.ctr < nbr_ctr_q[rx_idx_in];
    wire nwk_tag_bad = aes_tag != rx_q.nwk_tag;
    wire aps_tag_bad = aes_tag != rx_q.aps_tag;
    wire [7:0] nwk_ovh = `MFS_CTR_BYTES + `MFS_SRC_BYTES + `MFS_TAG_BYTES + `MFS_NWK_OTHER;
    wire [7:0] aps_ovh = `MFS_APS_HDR + `MFS_TAG_BYTES;
    // Key and receive take priority over transmit
    assign key_ready = (state_q == S_IDLE);
    assign rx_ready = (state_q == S_IDLE) && !key_valid;
    assign tx_ready = (state_q == S_IDLE) && !key_valid && !rx_valid;
    // Payload room left after security overhead
    assign tx_payload_cap = FRAME_MAX - nwk_ovh - (tx_req.aps_req ? aps_ovh : 8'h00);
    assign key_seq = seq_q;
    assign aes_valid = aes_valid_q;
    assign aes_cmd = aes_cmd_q;
    assign res_valid = res_valid_q;
    assign res = res_q;
    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        ctr_d = ctr_q;
        seq_d = seq_q;
        aps_tag_d = aps_tag_q;
        aes_valid_d = aes_valid_q && !aes_done;
        aes_cmd_d = aes_cmd_q;
        res_valid_d = 1'b0;
        res_d = res_q;
        nbr_clr = 1'b0;
        nbr_we = 1'b0;
        case (state_q)
            S_IDLE: begin
                aps_tag_d = `MFS_CTR_ZERO;
                res_d.ctr = ctr_q;
                res_d.nwk_tag = `MFS_CTR_ZERO;
                res_d.aps_tag = `MFS_CTR_ZERO;
                if (key_fire) begin
                    // Key events
                    res_valid_d = 1'b1;
                    if (key_req.op == K_ADOPT) begin
                        ctr_d = `MFS_CTR_ZERO;
                        nbr_clr = 1'b1;
                        seq_d = seq_q + `MFS_SEQ_ONE;
                        res_d.verdict = V_KEY_NEW;
                        res_d.ctr = `MFS_CTR_ZERO;
                    end else if (key_req.op == K_RECEIVE || (is_trust_centre
                                 && key_req.joiner_link)) begin
                        // Wrap or unwrap the network key under the link key
                        res_valid_d = 1'b0;
                        aes_valid_d = 1'b1;
                        aes_cmd_d = mk_aes((key_req.op == K_RECEIVE) ? A_UNWRAP : A_WRAP,
                                           1'b1, 1'b1, own_addr, ctr_q);
                        state_d = S_KEY;
                    end else if (is_trust_centre && allow_clear_key) begin
                        res_d.verdict = V_KEY_CLEAR;
                    end else begin
                        res_d.verdict = V_KEY_REFUSED;
                    end
                end else if (rx_fire) begin
                    // Received frames
                    res_d.ctr = rx_req.ctr;
                    if (!secured_kind(rx_req.kind)) begin
                        res_valid_d = 1'b1;
                        res_d.verdict = V_PLAIN;
                    end else if (replay) begin
                        res_valid_d = 1'b1;
                        res_d.verdict = V_REPLAY;
                    end else begin
                        aes_valid_d = 1'b1;
                        aes_cmd_d = mk_aes(A_DEC_AUTH, 1'b0, 1'b0, rx_req.src, rx_req.ctr);
                        state_d = S_RX_NWK;
                    end
                end else if (tx_fire) begin
                    // Outgoing frames
                    if (!secured_kind(tx_req.kind)) begin
                        res_valid_d = 1'b1;
                        res_d.verdict = V_PLAIN;
                    end else if (tx_req.bcast && tx_req.aps_req) begin
                        res_valid_d = 1'b1;
                        res_d.verdict = V_APS_BCAST;
                    end else if (exhausted) begin
                        res_valid_d = 1'b1;
                        res_d.verdict = V_EXHAUSTED;
                    end else if (tx_req.aps_req) begin
                        aes_valid_d = 1'b1;
                        aes_cmd_d = mk_aes(A_ENC_AUTH, 1'b1, 1'b1, own_addr, ctr_q);
                        state_d = S_TX_APS;
                    end else begin
                        aes_valid_d = 1'b1;
                        aes_cmd_d = mk_aes(A_ENC_AUTH, 1'b0, 1'b0, own_addr, ctr_q);
                        state_d = S_TX_NWK;
                    end
                end
            end
            S_TX_APS: begin
                // Application tag first, then network layer
                if (aes_done) begin
                    aps_tag_d = aes_tag;
                    aes_valid_d = 1'b1;
                    aes_cmd_d = mk_aes(A_ENC_AUTH, 1'b0, 1'b0, own_addr, ctr_q);
                    state_d = S_TX_NWK;
                end
            end
            S_TX_NWK, S_FWD: begin
                // Network tag appended, counter advanced
                if (aes_done) begin
                    res_valid_d = 1'b1;
                    res_d.verdict = (state_q == S_FWD) ? V_FORWARD : V_SENT;
                    res_d.ctr = ctr_q;
                    res_d.nwk_tag = aes_tag;
                    res_d.aps_tag = aps_tag_q;
                    ctr_d = ctr_q + `MFS_CTR_ONE;
                    state_d = S_IDLE;
                end
            end
            S_RX_NWK: begin
                // Network check decides drop, forward or delivery
                if (aes_done) begin
                    res_d.nwk_tag = aes_tag;
                    if (nwk_tag_bad) begin
                        res_valid_d = 1'b1;
                        res_d.verdict = V_NWK_TAG;
                        state_d = S_IDLE;
                    end else begin
                        nbr_we = 1'b1;
                        if (!rx_q.for_me) begin
                            if (exhausted) begin
                                res_valid_d = 1'b1;
                                res_d.verdict = V_EXHAUSTED;
                                state_d = S_IDLE;
                            end else begin
                                aes_valid_d = 1'b1;
                                aes_cmd_d = mk_aes(A_ENC_AUTH, 1'b0, 1'b0, own_addr, ctr_q);
                                aps_tag_d = rx_q.aps_tag;
                                state_d = S_FWD;
                            end
                        end else if (rx_q.aps_sec && rx_q.bcast) begin
                            res_valid_d = 1'b1;
                            res_d.verdict = V_APS_BCAST;
                            state_d = S_IDLE;
                        end else if (rx_q.aps_sec) begin
                            aes_valid_d = 1'b1;
                            aes_cmd_d = mk_aes(A_DEC_AUTH, 1'b1, 1'b1, rx_q.src, rx_q.ctr);
                            state_d = S_RX_APS;
                        end else begin
                            res_valid_d = 1'b1;
                            res_d.verdict = V_DELIVERED;
                            state_d = S_IDLE;
                        end
                    end
                end
            end
            S_RX_APS: begin
                // Destination removes application layer
                if (aes_done) begin
                    res_valid_d = 1'b1;
                    res_d.aps_tag = aes_tag;
                    res_d.verdict = aps_tag_bad ? V_APS_TAG : V_DELIVERED;
                    state_d = S_IDLE;
                end
            end
            S_KEY: begin
                // Joiner adopts received key; trust centre reports delivery
                if (aes_done) begin
                    res_valid_d = 1'b1;
                    if (key_q.op == K_RECEIVE) begin
                        ctr_d = `MFS_CTR_ZERO;
                        nbr_clr = 1'b1;
                        seq_d = seq_q + `MFS_SEQ_ONE;
                        res_d.ctr = `MFS_CTR_ZERO;
                        res_d.verdict = V_KEY_NEW;
                    end else begin
                        res_d.verdict = V_KEY_LINK;
                    end
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end
    // ----------------------------------------
    // Sequencer registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= S_IDLE;
            ctr_q <= `MFS_CTR_ZERO;
            seq_q <= `MFS_SEQ_ZERO;
            aps_tag_q <= `MFS_CTR_ZERO;
            aes_valid_q <= 1'b0;
            aes_cmd_q <= '0;
            res_valid_q <= 1'b0;
            res_q <= '0;
        end else begin
            state_q <= state_d;
            ctr_q <= ctr_d;
            seq_q <= seq_d;
            aps_tag_q <= aps_tag_d;
            aes_valid_q <= aes_valid_d;
            aes_cmd_q <= aes_cmd_d;
            res_valid_q <= res_valid_d;
            res_q <= res_d;
        end
    end
    // Requests held while the cipher works
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_q <= '0;
            key_q <= '0;
        end else begin
            rx_q <= rx_fire ? rx_req : rx_q;
            key_q <= key_fire ? key_req : key_q;
        end
    end
    // ----------------------------------------
    // Neighbour counter table
    // ----------------------------------------
    for (genvar i = 0; i < NBR_N; i++) begin : g_nbr
        wire hit = nbr_we && (rx_idx_q == NBR_W'(i));
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                nbr_ctr_q[i] <= `MFS_CTR_ZERO;
            end else if (nbr_clr) begin
                nbr_ctr_q[i] <= `MFS_CTR_ZERO;
            end else if (hit) begin
                nbr_ctr_q[i] <= rx_q.ctr;
            end
        end
    end
endmodule
